/* sar_adc_model.sv */
// behavioural converter model standing at the far side of the sequencer
`timescale 1ns/1ps
`include "sar_params.svh"

// ==========================================================================
// converter model
module sar_adc_model (
  input  wire logic                   clk_in,
  input  wire logic                   power_in,
  input  wire logic                   convert_in,
  input  wire logic [`SAR_CH_W-1:0]   channel_in,
  input  wire logic                   gen_in,
  output logic      [`SAR_DATA_W-1:0] data_out
);
  logic [`SAR_DATA_W-1:0] last_q = 10'h2A5;

  // result is valid only while powered and converting; otherwise the bus
  // toggles every cycle so a capture an odd number of cycles late can never match by luck
  assign data_out = (power_in && convert_in) ? {channel_in, 4'h6, gen_in}
                                             : ~last_q;

  // remember the last driven word, or keep flipping when released
  always @(posedge clk_in) begin
    last_q <= data_out;
  end
endmodule // sar_adc_model

/* sar_adc_readout_sequencer.sv */
// sar adc readout sequencer: timing, channel stepping and result capture
// What this block does
// - runs in single channel, round robin, or one time automatic mode
// - single mode converts only the selected channel, then interrupts
// - after enabling, waits the programmed enable delay before sampling
// - holds sampling for the programmed sample time before converting
// - conversion lasts exactly twelve clock cycles after sampling ends
// - at conversion end result is stored; in single mode the interrupt pulses two cycles
// - repeat in single mode restarts sampling right after the interrupt
// - round robin converts channel 0 upward, storing each own result
// - results are readable at any time without disturbing the sweep
// - each new round robin result overwrites that channel's old value
// - each automatic channel slot takes about 63.33 microseconds
// - one time mode sweeps like round robin but stops after last channel
// - one time mode interrupts once the whole sweep is converted
// - automatic sweeps cover only the auto-sequenced channels
`timescale 1ns/1ps
`include "sar_params.svh"

module sar_adc_readout_sequencer #(
  parameter int AUTO_CHAN_CYCLES = `SAR_AUTO_CHAN_CYCLES
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   enable_in,
  input  wire logic [1:0]             mode_in,
  input  wire logic                   start_in,
  input  wire logic                   repeat_in,
  input  wire logic [`SAR_CH_W-1:0]   channel_in,
  input  wire logic [`SAR_CNT_W-1:0]  en_delay_in,
  input  wire logic [`SAR_CNT_W-1:0]  sample_time_in,
  input  wire logic [`SAR_DATA_W-1:0] adc_data_in,
  input  wire logic [`SAR_CH_W-1:0]   rd_addr_in,
  output logic                        adc_power_out,
  output logic                        adc_sample_out,
  output logic                        adc_convert_out,
  output logic [`SAR_CH_W-1:0]        adc_channel_out,
  output logic                        irq_out,
  output logic                        busy_out,
  output logic [`SAR_DATA_W-1:0]      rd_data_out
);

  // ========================================================================
  // state
  sar_pkg::state_type      state_q, state_d;
  sar_pkg::mode_type       mode_q;
  logic [`SAR_CNT_W-1:0]   cnt_q, cnt_d;
  logic [`SAR_CNT_W-1:0]   slot_q, slot_d;
  logic [`SAR_CH_W-1:0]    chan_q, chan_d;
  logic                    warm_q;
  logic                    power_q;
  logic                    once_hold_q;

  sar_mem_if mem_bus ();

  // ========================================================================
  // decode
  wire mode_ok   = (mode_in == sar_pkg::MODE_SINGLE) ||
                   (mode_in == sar_pkg::MODE_ROUND)  ||
                   (mode_in == sar_pkg::MODE_ONCE);
  wire single_in = (mode_in == sar_pkg::MODE_SINGLE);
  // a finished one time sweep stays finished until mode or enable moves
  wire once_block = once_hold_q && (mode_in == sar_pkg::MODE_ONCE);
  wire go        = enable_in && mode_ok && !once_block &&
                   (!single_in || start_in);
  // a mode change mid-run is treated like a disable, so a half sweep
  // never continues under a different mode
  wire abort     = !enable_in ||
                   ((state_q != sar_pkg::ST_IDLE) &&
                    (mode_in != mode_q));
  wire en_done   = (cnt_q >= en_delay_in);
  wire smp_done  = (cnt_q >= sample_time_in);
  wire conv_done = (cnt_q == `SAR_CONV_CYCLES - 16'h0001);
  wire int_done  = (cnt_q == `SAR_INT_CYCLES - 16'h0001);
  wire slot_done = (slot_q >= 16'(AUTO_CHAN_CYCLES - 1));
  wire last_auto = (chan_q == `SAR_LAST_AUTO_CH);
  wire auto_run  = (mode_q != sar_pkg::MODE_SINGLE);
  wire once_end  = (mode_q == sar_pkg::MODE_ONCE) && last_auto;

  // ========================================================================
  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sar_pkg::ST_IDLE: begin
        if (go) begin
          state_d = warm_q ? sar_pkg::ST_SAMPLE : sar_pkg::ST_EN_WAIT;
        end
      end
      sar_pkg::ST_EN_WAIT: begin
        if (en_done) begin
          state_d = sar_pkg::ST_SAMPLE;
        end
      end
      sar_pkg::ST_SAMPLE: begin
        if (smp_done) begin
          state_d = sar_pkg::ST_CONVERT;
        end
      end
      sar_pkg::ST_CONVERT: begin
        if (conv_done) begin
          state_d = sar_pkg::ST_INTR;
        end
      end
      sar_pkg::ST_INTR: begin
        if (int_done) begin
          if (!auto_run) begin
            state_d = repeat_in ? sar_pkg::ST_SAMPLE
                                : sar_pkg::ST_IDLE;
          end else if (once_end) begin
            state_d = sar_pkg::ST_IDLE;
          end else begin
            state_d = sar_pkg::ST_SLOT;
          end
        end
      end
      sar_pkg::ST_SLOT: begin
        if (slot_done) begin
          state_d = sar_pkg::ST_SAMPLE;
        end
      end
      default: state_d = sar_pkg::ST_IDLE;
    endcase
    if (abort) begin
      state_d = sar_pkg::ST_IDLE;
    end
  end

  // phase counter restarts on every state change
  assign cnt_d  = (state_d != state_q) ? '0 : cnt_q + 16'h0001;
  // slot counter measures a channel slot from its sampling start
  assign slot_d = ((state_d == sar_pkg::ST_SAMPLE) &&
                   (state_q != sar_pkg::ST_SAMPLE)) ? '0 :
                  (slot_q == '1) ? slot_q : slot_q + 16'h0001;

  // channel select: firmware choice in single mode, stepping in auto
  always_comb begin
    chan_d = chan_q;
    if ((state_q == sar_pkg::ST_IDLE) && go) begin
      chan_d = single_in ? channel_in : `SAR_FIRST_AUTO_CH;
    end else if ((state_q == sar_pkg::ST_INTR) && int_done && auto_run) begin
      chan_d = last_auto ? `SAR_FIRST_AUTO_CH
                         : chan_q + 5'h01;
    end
  end

  // ========================================================================
  // registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= sar_pkg::ST_IDLE;
      cnt_q   <= '0;
      slot_q  <= '0;
      chan_q  <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      slot_q  <= slot_d;
      chan_q  <= chan_d;
    end
  end

  // mode latch and warm-up memory; warm_q drops on disable so the next
  // enable pays the enable delay again
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q  <= sar_pkg::MODE_SINGLE;
      warm_q  <= 1'b0;
      power_q <= 1'b0;
      once_hold_q <= 1'b0;
    end else begin
      power_q <= enable_in;
      if (!enable_in || (mode_in != sar_pkg::MODE_ONCE)) begin
        once_hold_q <= 1'b0;
      end else if ((state_q == sar_pkg::ST_INTR) && int_done && once_end) begin
        once_hold_q <= 1'b1;
      end
      if ((state_q == sar_pkg::ST_IDLE) && go) begin
        mode_q <= sar_pkg::mode_type'(mode_in);
      end
      if (!enable_in) begin
        warm_q <= 1'b0;
      end else if ((state_q == sar_pkg::ST_EN_WAIT) && en_done) begin
        warm_q <= 1'b1;
      end
    end
  end

  // ========================================================================
  // result capture and readout
  assign mem_bus.wr_en   = (state_q == sar_pkg::ST_CONVERT) &&
                           conv_done && !abort;
  assign mem_bus.wr_addr = chan_q;
  assign mem_bus.wr_data = adc_data_in;
  assign mem_bus.rd_addr = rd_addr_in;

  sar_result_mem result_store (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .port   (mem_bus.mem)
  );

  // ========================================================================
  // outputs; round robin raises no per-channel interrupt
  assign adc_power_out   = power_q;
  assign adc_sample_out  = (state_q == sar_pkg::ST_SAMPLE);
  assign adc_convert_out = (state_q == sar_pkg::ST_CONVERT);
  assign adc_channel_out = chan_q;
  assign irq_out         = (state_q == sar_pkg::ST_INTR) &&
                           (!auto_run || once_end);
  assign busy_out        = (state_q != sar_pkg::ST_IDLE);
  assign rd_data_out     = mem_bus.rd_data;

  // ========================================================================
  // checks
  // helper count of consecutive convert cycles; a long repetition in a
  // property would be costly to unroll, so the length is counted here
  logic [`SAR_CNT_W-1:0] conv_run_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_run_q <= '0;
    end else begin
      conv_run_q <= adc_convert_out ? conv_run_q + 16'h0001 : '0;
    end
  end

  // conversion ended with no abort in its last cycle
  sequence s_conv_end;
    $fell(adc_convert_out) && $past(enable_in) && $past(mode_in == mode_q);
  endsequence

  a_conv_length: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_conv_end |-> conv_run_q == `SAR_CONV_CYCLES
  ) else $error("conversion phase not twelve cycles");

  a_conv_bound: assert property (
    @(posedge clk_in) disable iff (rst_in)
    adc_convert_out |-> conv_run_q < `SAR_CONV_CYCLES
  ) else $error("conversion phase longer than twelve cycles");

  a_conv_before_irq: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $rose(irq_out) |-> (conv_run_q == `SAR_CONV_CYCLES) &&
      $past(mem_bus.wr_en)
  ) else $error("interrupt without full conversion and store");

  a_irq_two: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ($rose(irq_out) && enable_in && (mode_in == mode_q)) |=>
      (irq_out || !enable_in || (mode_in != mode_q)) ##1 !irq_out
  ) else $error("interrupt pulse not two cycles");

  a_en_delay: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ($past(state_q) == sar_pkg::ST_EN_WAIT) && (state_q == sar_pkg::ST_SAMPLE)
      |-> $past(cnt_q) == $past(en_delay_in)
  ) else $error("enable delay length wrong");

  a_sample_len: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ($past(state_q) == sar_pkg::ST_SAMPLE) && adc_convert_out
      |-> $past(cnt_q) == $past(sample_time_in)
  ) else $error("sampling length wrong");

  a_repeat_restart: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ((state_q == sar_pkg::ST_INTR) && int_done && !auto_run && repeat_in &&
      !abort) |=> adc_sample_out && !irq_out
  ) else $error("repeat did not restart sampling");

  a_disable_idle: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !enable_in |=> !busy_out && !adc_sample_out && !adc_convert_out
  ) else $error("disable did not abort");

  a_rr_wrap: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ((state_q == sar_pkg::ST_INTR) && int_done && !abort && last_auto &&
      (mode_q == sar_pkg::MODE_ROUND)) |=>
      (chan_q == `SAR_FIRST_AUTO_CH) && busy_out
  ) else $error("round robin did not wrap");

  a_once_stop: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ((state_q == sar_pkg::ST_INTR) && int_done && !abort && once_end)
      |-> irq_out ##1 !busy_out
  ) else $error("one time sweep did not stop with interrupt");

  a_once_hold: assert property (
    @(posedge clk_in) disable iff (rst_in)
    once_hold_q |-> !busy_out
  ) else $error("one time sweep restarted without a mode change");

  a_auto_range: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (busy_out && auto_run) |-> (chan_q <= `SAR_LAST_AUTO_CH)
  ) else $error("auto sweep left auto channels");

  a_slot_period: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ($past(state_q) == sar_pkg::ST_SLOT) && adc_sample_out
      |-> $past(slot_q) >= 16'(AUTO_CHAN_CYCLES - 1)
  ) else $error("auto slot shorter than period");

endmodule // sar_adc_readout_sequencer

/* sar_adc_readout_sequencer_test.sv */
// self-checking testbench for the sar adc readout sequencer
`timescale 1ns/1ps
`include "sar_params.svh"

module sar_adc_readout_sequencer_test;
  localparam int AUTO = 40;  // short slot so sweeps stay brief
  logic clk_in = 1'b0, rst_in = 1'b1, enable_in = 1'b0, start_in = 1'b0;
  logic repeat_in = 1'b0, gen = 1'b0, rd_pend = 1'b0;
  logic [1:0] mode_in = 2'h0;
  logic [`SAR_CH_W-1:0] channel_in = 5'h00, rd_addr_in = 5'h00, ch;
  logic [`SAR_CNT_W-1:0] en_delay_in = 16'h0000, sample_time_in = 16'h0000;
  logic [`SAR_DATA_W-1:0] adc_data_in, rd_data_out;
  logic adc_power_out, adc_sample_out, adc_convert_out, irq_out, busy_out;
  logic [`SAR_CH_W-1:0] adc_channel_out;
  logic [`SAR_CH_W-1:0] ch_q[$];
  logic [`SAR_DATA_W-1:0] rd_q[$];
  int stamp_q[$];
  int err_total = 0, total_checks = 0, cyc = 0, conv_starts = 0;
  int irq_pulses = 0, conv_n = 0, samp_n = 0, irq_n = 0, n, b, s, i;
  bit conv_p = 0, samp_p = 0, irq_p = 0;

  sar_adc_readout_sequencer #(.AUTO_CHAN_CYCLES(AUTO))
    sar_adc_readout_sequencer_i (.clk_in(clk_in), .rst_in(rst_in),
    .enable_in(enable_in), .mode_in(mode_in), .start_in(start_in),
    .repeat_in(repeat_in), .channel_in(channel_in),
    .en_delay_in(en_delay_in), .sample_time_in(sample_time_in),
    .adc_data_in(adc_data_in), .rd_addr_in(rd_addr_in),
    .adc_power_out(adc_power_out), .adc_sample_out(adc_sample_out),
    .adc_convert_out(adc_convert_out), .adc_channel_out(adc_channel_out),
    .irq_out(irq_out), .busy_out(busy_out), .rd_data_out(rd_data_out));

  sar_adc_model sar_adc_model_i (.clk_in(clk_in), .power_in(adc_power_out),
    .convert_in(adc_convert_out), .channel_in(adc_channel_out),
    .gen_in(gen), .data_out(adc_data_in));

  // ========================================================================
  // clock, shared tasks
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  function automatic logic [`SAR_DATA_W-1:0] res(input logic [4:0] c,
                                                 input logic g);
    return {c, 4'h6, g};
  endfunction

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // read requests are noted here and judged by the monitor
  task automatic rd_note(input logic [4:0] a, input logic [9:0] e);
    rd_addr_in = a;
    rd_q.push_back(e);
    rd_pend = 1'b1;
    @(negedge clk_in);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ========================================================================
  // monitor: samples settled outputs just after each rising edge
  always @(posedge clk_in) begin
    #1;
    cyc++;
    if (adc_convert_out === 1'b1 && !conv_p) begin
      conv_starts++;
      stamp_q.push_back(cyc);
      if (ch_q.size() == 0)
        check("unexpected conversion", 16'h0001, 16'h0000);
      else
        check("channel", 16'(adc_channel_out), 16'(ch_q.pop_front()));
    end
    // convert and sample lengths are skipped on a disable, where phases are cut short on purpose
    if (adc_convert_out !== 1'b1 && conv_p && enable_in)
      check("convert length", 16'(conv_n), 16'h000C);
    if (adc_sample_out !== 1'b1 && samp_p && enable_in)
      check("sample length", 16'(samp_n), sample_time_in + 16'h0001);
    if (irq_out !== 1'b1 && irq_p) begin
      irq_pulses++;
      check("irq length", 16'(irq_n), 16'h0002);
    end
    if (rd_pend)
      check("result", 16'(rd_data_out), 16'(rd_q.pop_front()));
    conv_n = (adc_convert_out === 1'b1) ? conv_n + 1 : 0;
    samp_n = (adc_sample_out === 1'b1) ? samp_n + 1 : 0;
    irq_n = (irq_out === 1'b1) ? irq_n + 1 : 0;
    conv_p = (adc_convert_out === 1'b1);
    samp_p = (adc_sample_out === 1'b1);
    irq_p = (irq_out === 1'b1);
  end

  // watchdog: the whole sequence needs about a thousand cycles, the limit is 20000
  initial begin
    #100000;
    err_total++;
    final_report();
  end

  // ========================================================================
  // driver
  initial begin
    n = $urandom(32'h26E0);
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    // single channel, cold start: enable delay then one conversion
    en_delay_in = 16'($urandom % 8);
    sample_time_in = 16'($urandom % 4);
    ch = 5'(11 + $urandom % 21);
    channel_in = ch;
    ch_q.push_back(ch);
    enable_in = 1'b1;
    start_in = 1'b1;
    n = 0;
    for (i = 0; i < 100 && adc_sample_out !== 1'b1; i++) begin
      @(negedge clk_in);
      n++;
    end
    start_in = 1'b0;
    check("enable delay", 16'(n), en_delay_in + 16'h0002);
    check("power on", 16'(adc_power_out), 16'h0001);
    for (i = 0; i < 200 && busy_out !== 1'b0; i++) @(negedge clk_in);
    check("single idle", 16'(busy_out), 16'h0000);
    rd_note(ch, res(ch, 1'b0));
    rd_pend = 1'b0;
    $display("test single done");
    // repeat: a new sample must follow the interrupt at once
    ch_q.push_back(ch);
    ch_q.push_back(ch);
    repeat_in = 1'b1;
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    // wait for the first interrupt to start, then for it to end
    for (i = 0; i < 200 && irq_out !== 1'b1; i++) @(negedge clk_in);
    for (i = 0; i < 200 && irq_out === 1'b1; i++) @(negedge clk_in);
    check("repeat restart", 16'(adc_sample_out), 16'h0001);
    @(negedge clk_in);
    repeat_in = 1'b0;
    for (i = 0; i < 200 && busy_out !== 1'b0; i++) @(negedge clk_in);
    $display("test repeat done");
    // reserved mode code must not start anything
    mode_in = 2'h3;
    repeat (20) @(negedge clk_in);
    check("mode 3 idle", 16'(busy_out), 16'h0000);
    // round robin: order, slot spacing, wrap, overwrite, abort
    for (i = 0; i < 13; i++) ch_q.push_back(5'(i % 11));
    b = conv_starts;
    s = stamp_q.size();
    mode_in = 2'h1;  // no averaging input: one sample per conversion
    for (i = 0; i < 2000 && conv_starts < b + 12; i++) @(negedge clk_in);
    gen = 1'b1;
    rd_note(ch, res(ch, 1'b0));
    rd_pend = 1'b0;
    for (i = 0; i < 2000 && conv_starts < b + 13; i++) @(negedge clk_in);
    repeat (3) @(negedge clk_in);
    enable_in = 1'b0;
    @(negedge clk_in);
    check("abort idle", 16'(busy_out), 16'h0000);
    check("power off", 16'(adc_power_out), 16'h0000);
    for (i = 0; i < 12; i++)
      check("slot spacing", 16'(stamp_q[s+i+1] - stamp_q[s+i]),
            16'(AUTO));
    rd_note(5'h00, res(5'h00, 1'b1));
    for (i = 1; i < 11; i++) rd_note(5'(i), res(5'(i), 1'b0));
    rd_pend = 1'b0;
    gen = 1'b0;
    $display("test round robin done");
    // one time sweep: eleven channels, one interrupt, then stop
    for (i = 0; i < 11; i++) ch_q.push_back(5'(i));
    b = irq_pulses;
    n = conv_starts;
    mode_in = 2'h2;
    enable_in = 1'b1;
    for (i = 0; i < 100 && busy_out !== 1'b1; i++) @(negedge clk_in);
    for (i = 0; i < 1000 && busy_out !== 1'b0; i++) @(negedge clk_in);
    // mode is left at one time: the finished sweep must not run again
    repeat (50) @(negedge clk_in);
    check("sweep stopped", 16'(busy_out), 16'h0000);
    mode_in = 2'h0;
    check("sweep irq count", 16'(irq_pulses - b), 16'h0001);
    check("sweep length", 16'(conv_starts - n), 16'h000B);
    rd_note(5'h00, res(5'h00, 1'b0));
    rd_pend = 1'b0;
    $display("test one time done");
    final_report();
  end
endmodule // sar_adc_readout_sequencer_test

/* sar_mem_if.sv */
// result memory port bundle between sequencer and result store
`timescale 1ns/1ps
`include "sar_params.svh"

interface sar_mem_if;
  logic                   wr_en;
  logic [`SAR_CH_W-1:0]   wr_addr;
  logic [`SAR_DATA_W-1:0] wr_data;
  logic [`SAR_CH_W-1:0]   rd_addr;
  logic [`SAR_DATA_W-1:0] rd_data;

  modport seq (output wr_en, output wr_addr, output wr_data,
               output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_addr, output rd_data);
endinterface

/* sar_params.svh */
// constants for the sar adc readout sequencer
`ifndef SAR_SEQ_PARAMS_SVH
`define SAR_SEQ_PARAMS_SVH

// ==========================================================================
// widths and sizes
`define SAR_CH_W        5
`define SAR_DATA_W      10
`define SAR_CNT_W       16
`define SAR_NUM_CH      32

// ==========================================================================
// timing
`define SAR_CLK_MHZ          200
`define SAR_CONV_CYCLES      16'h000C
`define SAR_INT_CYCLES       16'h0002
`define SAR_AUTO_CHAN_NS     63330
`define SAR_AUTO_CHAN_CYCLES ((`SAR_AUTO_CHAN_NS * `SAR_CLK_MHZ) / 1000)

// ==========================================================================
// channel limits
`define SAR_FIRST_AUTO_CH  5'h00
`define SAR_LAST_AUTO_CH   5'h0A

`endif

/* sar_pkg.sv */
// types shared by the sar adc readout sequencer
package sar_pkg;

  // ========================================================================
  // operating modes
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_ROUND  = 2'h1,
    MODE_ONCE   = 2'h2
  } mode_type;

  // ========================================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_EN_WAIT = 3'h1,
    ST_SAMPLE  = 3'h2,
    ST_CONVERT = 3'h3,
    ST_INTR    = 3'h4,
    ST_SLOT    = 3'h5
  } state_type;

endpackage

/* sar_result_mem.sv */
// per-channel result store with one write and one registered read port
`timescale 1ns/1ps
`include "sar_params.svh"

module sar_result_mem (
  input wire logic clk_in,
  input wire logic rst_in,
  sar_mem_if.mem   port
);

  logic [`SAR_DATA_W-1:0] store_q [`SAR_NUM_CH];
  logic [`SAR_DATA_W-1:0] rd_q;

  // ========================================================================
  // storage: no reset on the array, results survive an abort
  always_ff @(posedge clk_in) begin
    if (port.wr_en) begin
      store_q[port.wr_addr] <= port.wr_data;
    end
  end

  // read port is independent of writes, so reads never stall a sweep
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q <= '0;
    end else begin
      rd_q <= store_q[port.rd_addr];
    end
  end

  assign port.rd_data = rd_q;

endmodule // sar_result_mem
